// ==== include/mstop_pkg.sv ====
// constants for the module stop control block: offsets, bit
// positions, reset values and the sleep-halt states.
// assumes a 32-bit apb slave port with byte addressing.
`default_nettype none

package mstop_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;

	localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

	// first register: stored bits, fixed-one and fixed-zero bits
	localparam logic [REG_W-1:0] CTRL_A_IMPL = 16'h9329;
	localparam logic [REG_W-1:0] CTRL_A_ONES = 16'h0cd6;
	localparam logic [REG_W-1:0] CTRL_A_ZERO = 16'h6000;
	localparam logic [REG_W-1:0] CTRL_A_RST  = 16'h0fff;

	// second register: unused bits read as one
	localparam logic [REG_W-1:0] CTRL_B_IMPL = 16'h9700;
	localparam logic [REG_W-1:0] CTRL_B_ONES = 16'h68ff;
	localparam logic [REG_W-1:0] CTRL_B_RST  = 16'hffff;

	localparam int BIT_CLK_STOP_EN = 15;
	localparam int BIT_XFER        = 12;
	localparam int BIT_TIMER_HI    = 9;
	localparam int BIT_TIMER_LO    = 8;
	localparam int BIT_DAC         = 5;
	localparam int BIT_ADC         = 3;
	localparam int BIT_PULSE       = 0;

	localparam int BIT_PATTERN     = 15;
	localparam int BIT_SER4        = 12;
	localparam int BIT_SER2        = 10;
	localparam int BIT_SER1        = 9;
	localparam int BIT_SER0        = 8;

	localparam int STS_ALL_STOPPED = 0;
	localparam int STS_CLK_HALT    = 1;

	typedef enum logic {
		ACS_RUN,
		ACS_HALT
	} acs_state_t;

endpackage : mstop_pkg

`default_nettype wire

// ==== design/stop_ctrl_reg.sv ====
// one software register of stop bits; only the bits in IMPL are
// stored, the rest hold zero. assumes a write strobe on the clock.
`default_nettype none
`timescale 1ns/10ps

module stop_ctrl_reg #(
	parameter int          WIDTH = 16,
	parameter logic [15:0] RST   = 16'hffff,
	parameter logic [15:0] IMPL  = 16'hffff
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic      [WIDTH-1:0] q
);

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RST[WIDTH-1:0] & IMPL[WIDTH-1:0];
		end else if (wr_en) begin
			q <= wr_data & IMPL[WIDTH-1:0];
		end
	end

endmodule : stop_ctrl_reg

`default_nettype wire

// ==== design/module_stop_control.sv ====
// module stop control: two stop registers on apb, registered stop
// levels to the peripherals and the sleep-time bus/io halt.
// assumes cpu_sleep is a level on clk, high while the cpu sleeps.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
`timescale 1ns/10ps

// Summary of operation
// - writing one stops a module, writing zero lets it run again
// - enable bit halts bus and io on sleep once all modules stop
// - halt enable: zero off, one on, resets to zero
// - bits 14 and 13 of first register read zero
// - bits 11,10,7,6,4,2,1 of first register read one
// - bit 12 stops transfer controller, resets to run
// - bits 9 and 8 stop the byte timer pairs, reset stopped
// - bit 5 stops the dac, bit 3 the adc, reset stopped
// - bit 0 stops the pulse timer unit, reset stopped
// - a stop change acts after the bus cycle, cpu keeps running
// - stopped module blocks its registers, keeps state except serial
// - second register: bit 15 pattern gen, 12,10,9,8 serial channels
module module_stop_control (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [mstop_pkg::ADDR_W-1:0] paddr,
	input  wire logic [mstop_pkg::DATA_W-1:0] pwdata,
	output logic      [mstop_pkg::DATA_W-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        cpu_sleep,
	output logic                             xfer_ctrl_stop,
	output logic                             byte_timer_hi_stop,
	output logic                             byte_timer_lo_stop,
	output logic                             dac_stop,
	output logic                             adc_stop,
	output logic                             pulse_timer_stop,
	output logic                             pattern_gen_stop,
	output logic                             serial4_stop,
	output logic                             serial2_stop,
	output logic                             serial1_stop,
	output logic                             serial0_stop,
	output logic                             all_clock_stop
);

	import mstop_pkg::*;

	////////////////////////////////////////////////////////////////
	// apb decode

	logic              access;
	logic              wr_done;
	logic              wr_a;
	logic              wr_b;
	logic              hit_a;
	logic              hit_b;
	logic              hit_s;
	logic [REG_W-1:0]  ctrl_a_q;
	logic [REG_W-1:0]  ctrl_b_q;
	logic [REG_W-1:0]  rd_nxt;
	logic              all_stopped;
	logic              clk_stop_en;
	acs_state_t        state_r;
	acs_state_t        state_nxt;

	// one wait state: the answer comes on the second access cycle
	assign access  = psel && penable;
	assign wr_done = access && pready && pwrite;
	assign hit_a   = (paddr == OFS_CTRL_A);
	assign hit_b   = (paddr == OFS_CTRL_B);
	assign hit_s   = (paddr == OFS_STATUS);
	assign wr_a    = wr_done && hit_a;
	assign wr_b    = wr_done && hit_b;

	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= access && !pready;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= access && !pready && !(hit_a || hit_b || hit_s);
		end
	end

	////////////////////////////////////////////////////////////////
	// stop registers

	// writes land only at the completing edge of the access
	stop_ctrl_reg #(
		.WIDTH (REG_W),
		.RST   (CTRL_A_RST),
		.IMPL  (CTRL_A_IMPL)
	) u_ctrl_a (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_a),
		.wr_data (pwdata[REG_W-1:0]),
		.q       (ctrl_a_q)
	);

	stop_ctrl_reg #(
		.WIDTH (REG_W),
		.RST   (CTRL_B_RST),
		.IMPL  (CTRL_B_IMPL)
	) u_ctrl_b (
		.clk     (clk),
		.rst     (rst),
		.wr_en   (wr_b),
		.wr_data (pwdata[REG_W-1:0]),
		.q       (ctrl_b_q)
	);

	assign clk_stop_en = ctrl_a_q[BIT_CLK_STOP_EN];

	// transfer controller counts as a controlled module too; the enable
	// bit is no module, so it is masked out of the full-stop test
	localparam logic [REG_W-1:0] STOP_MASK_A = CTRL_A_IMPL & ~(16'h0001 << BIT_CLK_STOP_EN);
	assign all_stopped =
		((ctrl_a_q & STOP_MASK_A) == STOP_MASK_A)
		&& (ctrl_b_q == CTRL_B_IMPL);

	////////////////////////////////////////////////////////////////
	// read data

	always_comb begin
		rd_nxt = '0;
		if (hit_a) begin
			rd_nxt = (ctrl_a_q & ~CTRL_A_ZERO) | CTRL_A_ONES;
		end else if (hit_b) begin
			rd_nxt = ctrl_b_q | CTRL_B_ONES;
		end else if (hit_s) begin
			rd_nxt[STS_ALL_STOPPED] = all_stopped;
			rd_nxt[STS_CLK_HALT]    = (state_r == ACS_HALT);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= '0;
		end else if (access && !pready && !pwrite) begin
			prdata <= {{(DATA_W-REG_W){1'b0}}, rd_nxt};
		end
	end

	////////////////////////////////////////////////////////////////
	// stop outputs

	// one flop after the register so a stop acts once the bus cycle
	// has ended; the peripheral gates its own register port on it
	always_ff @(posedge clk) begin
		if (rst) begin
			xfer_ctrl_stop     <= CTRL_A_RST[BIT_XFER];
			byte_timer_hi_stop <= CTRL_A_RST[BIT_TIMER_HI];
			byte_timer_lo_stop <= CTRL_A_RST[BIT_TIMER_LO];
			dac_stop           <= CTRL_A_RST[BIT_DAC];
			adc_stop           <= CTRL_A_RST[BIT_ADC];
			pulse_timer_stop   <= CTRL_A_RST[BIT_PULSE];
			pattern_gen_stop   <= CTRL_B_RST[BIT_PATTERN];
			serial4_stop       <= CTRL_B_RST[BIT_SER4];
			serial2_stop       <= CTRL_B_RST[BIT_SER2];
			serial1_stop       <= CTRL_B_RST[BIT_SER1];
			serial0_stop       <= CTRL_B_RST[BIT_SER0];
		end else begin
			xfer_ctrl_stop     <= ctrl_a_q[BIT_XFER];
			byte_timer_hi_stop <= ctrl_a_q[BIT_TIMER_HI];
			byte_timer_lo_stop <= ctrl_a_q[BIT_TIMER_LO];
			dac_stop           <= ctrl_a_q[BIT_DAC];
			adc_stop           <= ctrl_a_q[BIT_ADC];
			pulse_timer_stop   <= ctrl_a_q[BIT_PULSE];
			pattern_gen_stop   <= ctrl_b_q[BIT_PATTERN];
			serial4_stop       <= ctrl_b_q[BIT_SER4];
			serial2_stop       <= ctrl_b_q[BIT_SER2];
			serial1_stop       <= ctrl_b_q[BIT_SER1];
			serial0_stop       <= ctrl_b_q[BIT_SER0];
		end
	end

	////////////////////////////////////////////////////////////////
	// bus and io halt while sleeping

	// leaves halt as soon as the cpu wakes; the cpu itself is
	// never stopped here, only the bus controller and io ports
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ACS_RUN: begin
				if (cpu_sleep && clk_stop_en && all_stopped) begin
					state_nxt = ACS_HALT;
				end
			end
			ACS_HALT: begin
				if (!cpu_sleep || !clk_stop_en || !all_stopped) begin
					state_nxt = ACS_RUN;
				end
			end
			default: begin
				state_nxt = ACS_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r        <= ACS_RUN;
			all_clock_stop <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			all_clock_stop <= (state_nxt == ACS_HALT);
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (rst);

	sequence s_wr_a;
		psel && penable && pready && pwrite && (paddr == OFS_CTRL_A);
	endsequence

	sequence s_wr_b;
		psel && penable && pready && pwrite && (paddr == OFS_CTRL_B);
	endsequence

	sequence s_rd_a;
		psel && penable && pready && !pwrite && (paddr == OFS_CTRL_A);
	endsequence

	sequence s_rd_b;
		psel && penable && pready && !pwrite && (paddr == OFS_CTRL_B);
	endsequence

	sequence s_rd_s;
		psel && penable && pready && !pwrite && (paddr == OFS_STATUS);
	endsequence

	chk_stop_set_pulse: assert property (
		s_wr_a and pwdata[BIT_PULSE] |-> ##2 pulse_timer_stop
	) else $error("pulse timer stop not set by write");

	chk_stop_clr_pulse: assert property (
		s_wr_a and !pwdata[BIT_PULSE] |-> ##2 !pulse_timer_stop
	) else $error("pulse timer stop not cleared by write");

	chk_halt_cause: assert property (
		$rose(all_clock_stop) |-> $past(clk_stop_en && all_stopped && cpu_sleep)
	) else $error("bus halt without enable, full stop and sleep");

	chk_halt_wake: assert property (
		all_clock_stop && !cpu_sleep |=> !all_clock_stop
	) else $error("bus halt held after wake");

	chk_enable_reset: assert property (
		$past(rst) |-> !clk_stop_en && !all_clock_stop
	) else $error("halt enable not zero after reset");

	chk_resv_zero: assert property (
		s_rd_a |-> (prdata[REG_W-1:0] & CTRL_A_ZERO) == 16'h0000
	) else $error("first register zero bits read as one");

	chk_resv_one: assert property (
		s_rd_a |-> (prdata[REG_W-1:0] & CTRL_A_ONES) == CTRL_A_ONES
	) else $error("first register one bits read as zero");

	chk_xfer_reset: assert property (
		$past(rst) |-> !xfer_ctrl_stop && !ctrl_a_q[BIT_XFER]
	) else $error("transfer controller stopped after reset");

	chk_timer_reset: assert property (
		$past(rst) |-> byte_timer_hi_stop && byte_timer_lo_stop
	) else $error("byte timers running after reset");

	chk_conv_reset: assert property (
		$past(rst) |-> dac_stop && adc_stop
	) else $error("converters running after reset");

	chk_pulse_reset: assert property (
		$past(rst) |-> pulse_timer_stop
	) else $error("pulse timer running after reset");

	chk_stop_lag: assert property (
		!$past(rst) |-> adc_stop == $past(ctrl_a_q[BIT_ADC])
	) else $error("adc stop does not follow its bit by one cycle");

	chk_pattern_write: assert property (
		s_wr_b |-> ##2 pattern_gen_stop == $past(pwdata[BIT_PATTERN], 2)
	) else $error("pattern gen stop does not follow write");

	chk_resv_b_one: assert property (
		s_rd_b |-> (prdata[REG_W-1:0] & CTRL_B_ONES) == CTRL_B_ONES
	) else $error("second register spare bits read as zero");

	chk_stop_hold: assert property (
		!wr_b ##1 !wr_b |=> $stable(serial0_stop) && $stable(serial4_stop)
	) else $error("serial stop changed without a write");

	chk_ready_pulse: assert property (
		pready |=> !pready
	) else $error("ready held longer than one cycle");

	chk_unmapped_err: assert property (
		pready && !(hit_a || hit_b || hit_s) |-> pslverr
	) else $error("unmapped access not flagged");

	chk_halt_entry: assert property (
		clk_stop_en && all_stopped && cpu_sleep |=> all_clock_stop
	) else $error("bus halt not entered on sleep with all stopped");

	chk_xfer_lag: assert property (
		!$past(rst) |-> xfer_ctrl_stop == $past(ctrl_a_q[BIT_XFER])
	) else $error("transfer stop does not follow its bit");

	chk_timer_lag: assert property (
		!$past(rst) |-> byte_timer_hi_stop == $past(ctrl_a_q[BIT_TIMER_HI])
			&& byte_timer_lo_stop == $past(ctrl_a_q[BIT_TIMER_LO])
	) else $error("byte timer stops do not follow their bits");

	chk_dac_lag: assert property (
		!$past(rst) |-> dac_stop == $past(ctrl_a_q[BIT_DAC])
	) else $error("dac stop does not follow its bit");

	chk_pulse_lag: assert property (
		!$past(rst) |-> pulse_timer_stop == $past(ctrl_a_q[BIT_PULSE])
	) else $error("pulse timer stop does not follow its bit");

	chk_serial_lag: assert property (
		!$past(rst) |-> {serial4_stop, serial2_stop, serial1_stop, serial0_stop}
			== $past({ctrl_b_q[BIT_SER4], ctrl_b_q[BIT_SER2], ctrl_b_q[BIT_SER1],
			ctrl_b_q[BIT_SER0]})
	) else $error("serial stops do not follow their bits");

	chk_status_read: assert property (
		s_rd_s |-> prdata[STS_ALL_STOPPED] == $past(all_stopped)
			&& prdata[STS_CLK_HALT] == $past(state_r == ACS_HALT)
	) else $error("status read does not match halt state");

	chk_unmapped_keep: assert property (
		pready && pslverr |=> $stable(ctrl_a_q) && $stable(ctrl_b_q)
	) else $error("unmapped write changed a stop register");

endmodule : module_stop_control

`default_nettype wire

// ==== sim/periph_model.sv ====
// peripheral side: a counter per module that runs while its stop is low
// assumes stop levels on clk; stops[3:0] are the serial channels
`timescale 1ns/10ps
`default_nettype none

module periph_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [10:0] stops,
	output logic      [43:0] pcnt
);
	always_ff @(posedge clk) begin
		for (int i = 0; i < 11; i++) begin
			// serial channels lose their state when stopped
			if (rst || (stops[i] && i < 4)) begin
				pcnt[4*i +: 4] <= 4'h0;
			end else if (!stops[i]) begin
				pcnt[4*i +: 4] <= pcnt[4*i +: 4] + 4'h1;
			end
		end
	end
endmodule : periph_model

`default_nettype wire

// ==== sim/tb_top.sv ====
// bench: apb register tests, stop levels and the sleep-time halt
// assumes the stop block and the peripheral model on one clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
	import mstop_pkg::*;
	logic              clk, rst, psel, penable, pwrite, cpu_sleep, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, rd;
	wire logic [31:0]  prdata;
	wire logic         pready, pslverr, acs;
	wire logic [10:0]  stops;
	wire logic [43:0]  pcnt;
	logic [43:0]       snap;
	int                n_fail, num_checks;

	module_stop_control module_stop_control_inst (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_sleep(cpu_sleep), .xfer_ctrl_stop(stops[10]),
		.byte_timer_hi_stop(stops[9]), .byte_timer_lo_stop(stops[8]),
		.dac_stop(stops[7]), .adc_stop(stops[6]), .pulse_timer_stop(stops[5]),
		.pattern_gen_stop(stops[4]), .serial4_stop(stops[3]),
		.serial2_stop(stops[2]), .serial1_stop(stops[1]),
		.serial0_stop(stops[0]), .all_clock_stop(acs));
	periph_model periph_model_inst (.clk(clk), .rst(rst), .stops(stops),
		.pcnt(pcnt));

	////////////////////////////////////////////////////////////////////
	function automatic logic [10:0] exp_stops(input logic [15:0] a,
		input logic [15:0] b);
		return {a[BIT_XFER], a[BIT_TIMER_HI], a[BIT_TIMER_LO], a[BIT_DAC],
			a[BIT_ADC], a[BIT_PULSE], b[BIT_PATTERN], b[BIT_SER4], b[BIT_SER2],
			b[BIT_SER1], b[BIT_SER0]};
	endfunction : exp_stops

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		if (n == 16) begin
			n_fail++;
			$display("CHECK FAILED %0t apb answer timed out", $time);
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(err, 1'b0)
	endtask : rchk

	// software keeps reserved bits at their fixed values
	task automatic wr_chk(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] av, bv;
		av = (a & CTRL_A_IMPL) | CTRL_A_ONES;
		bv = (b & CTRL_B_IMPL) | CTRL_B_ONES;
		apb(1'b1, OFS_CTRL_A, {16'h0, av});
		apb(1'b1, OFS_CTRL_B, {16'h0, bv});
		repeat (2) @(posedge clk);
		#1;
		`CHK(stops, exp_stops(av, bv))
		rchk(OFS_CTRL_A, {16'h0, av});
		rchk(OFS_CTRL_B, {16'h0, bv});
	endtask : wr_chk

	task automatic sleep_chk(input logic e);
		cpu_sleep <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		`CHK(acs, e)
		@(posedge clk);
		cpu_sleep <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(acs, 1'b0)
	endtask : sleep_chk

	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#200us;
		n_fail++;
		end_sim();
	end

	initial begin
		{rst, psel, penable, pwrite, cpu_sleep, err} = 6'h20;
		{paddr, pwdata, rd, snap, n_fail, num_checks} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(stops, 11'h3ff)
		`CHK(acs, 1'b0)
		rchk(OFS_CTRL_A, 32'h0000_0fff);
		rchk(OFS_CTRL_B, 32'h0000_ffff);
		rchk(OFS_STATUS, 32'h0);
		$display("test reset done");
		// walk a single running module through every bit of both
		for (int i = 0; i < 16; i++) begin
			wr_chk(~(16'h1 << i), 16'hffff);
			wr_chk(16'hffff, ~(16'h1 << i));
		end
		$display("test bit walk done");
		wr_chk(16'h0000, 16'h0000);
		snap = pcnt;
		repeat (4) @(posedge clk);
		`CHK(pcnt == snap, 1'b0)
		wr_chk(16'h7fff, 16'hffff);
		snap = pcnt;
		repeat (5) @(posedge clk);
		`CHK(pcnt, snap)
		`CHK(pcnt[15:0], 16'h0)
		$display("test retention done");
		sleep_chk(1'b0);
		wr_chk(16'hfffe, 16'hffff);
		sleep_chk(1'b0);
		wr_chk(16'hffff, 16'hffff);
		sleep_chk(1'b1);
		rchk(OFS_STATUS, 32'h1);
		cpu_sleep <= 1'b1;
		rchk(OFS_STATUS, 32'h3);
		cpu_sleep <= 1'b0;
		$display("test halt done");
		apb(1'b1, 8'h0c, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h0c, 32'h0);
		`CHK(rd, 32'h0)
		rchk(OFS_CTRL_A, 32'h0000_9fff);
		$display("test unmapped done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(stops, 11'h3ff)
		`CHK(acs, 1'b0)
		rchk(OFS_CTRL_A, 32'h0000_0fff);
		$display("test mid-run reset done");
		end_sim();
	end
endmodule : tb_top

`default_nettype wire
